// ===== design/dac_sched_pkg.sv
/*
 * Shared constants for the dual converter update scheduler: register
 * byte addresses, control field positions, reset values and modes.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
package dac_sched_pkg;

    // register byte addresses (one aligned word each)
    localparam logic [7:0] ADDR_DATA_HIGH = 8'h00;
    localparam logic [7:0] ADDR_DATA_LOW = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_B_DATA_HIGH = 8'h0c;
    localparam logic [7:0] ADDR_B_DATA_LOW = 8'h10;
    localparam logic [7:0] ADDR_B_CONTROL = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;

    // control register layout
    localparam int CTRL_ENABLE_BIT = 7;
    localparam int CTRL_MODE_LSB = 3;
    localparam int CTRL_FORMAT_LSB = 0;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h9f;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [11:0] CODE_RESET = 12'h000;

    // update mode encodings
    typedef enum logic [1:0] {
        MODE_ON_WRITE = 2'h0,
        MODE_TIMER3 = 2'h1,
        MODE_TIMER4 = 2'h2,
        MODE_TIMER2 = 2'h3
    } update_mode_t;

endpackage : dac_sched_pkg

// ===== design/dac_channel.sv
/*
 * One converter channel: justifies the held data bytes into a 12-bit
 * code and loads the input latch on a high-byte write or on the chosen
 * timer overflow.
 * Assumes byte write strobes and timer overflows are one-cycle pulses.
 */
`timescale 1ns/100ps
`default_nettype none

module dac_channel (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // held registers
    input wire logic [7:0] data_high,
    input wire logic [7:0] data_low,
    input wire logic [7:0] control,
    input wire logic high_write,
    // timer overflow pulses
    input wire logic timer2_ovf,
    input wire logic timer3_ovf,
    input wire logic timer4_ovf,
    // converter side
    output logic [11:0] code,
    output logic converter_on,
    output logic output_drive,
    output logic update_pulse
);

    dac_sched_pkg::update_mode_t mode;
    logic [2:0] fmt;
    logic load;
    logic [11:0] code_reg;
    logic [11:0] word;
    logic upd_reg;
    logic hw_dly_reg;

    // justify the 12-bit word across the two bytes
    function automatic logic [11:0] justify(input logic [2:0] f,
                                            input logic [7:0] hi,
                                            input logic [7:0] lo);
        logic [15:0] cat;
        cat = {hi, lo};
        case (f)
            3'h0: justify = cat[11:0];
            3'h1: justify = cat[12:1];
            3'h2: justify = cat[13:2];
            3'h3: justify = cat[14:3];
            default: justify = cat[15:4];
        endcase
    endfunction : justify

    assign mode = dac_sched_pkg::update_mode_t'(
        control[dac_sched_pkg::CTRL_MODE_LSB +: 2]);
    assign fmt = control[dac_sched_pkg::CTRL_FORMAT_LSB +: 3];
    assign word = justify(fmt, data_high, data_low);

    // the high byte lands in its register at the write edge, so the
    // load waits one cycle and takes the new byte, not the old one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hw_dly_reg <= 1'b0;
        end else begin
            hw_dly_reg <= high_write;
        end
    end

    // pick the single event that may load the latch
    always_comb begin
        case (mode)
            dac_sched_pkg::MODE_ON_WRITE: load = hw_dly_reg;
            dac_sched_pkg::MODE_TIMER3: load = timer3_ovf;
            dac_sched_pkg::MODE_TIMER4: load = timer4_ovf;
            dac_sched_pkg::MODE_TIMER2: load = timer2_ovf;
            default: load = 1'b0;
        endcase
    end

    // input latch: one load per event, full 12-bit range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_reg <= dac_sched_pkg::CODE_RESET;
        end else if (load) begin
            code_reg <= word;
        end
    end

    // update marker follows the load by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upd_reg <= 1'b0;
        end else begin
            upd_reg <= load;
        end
    end

    assign code = code_reg;
    assign update_pulse = upd_reg;
    // disabled channel: pin floats and converter sleeps
    assign converter_on = control[dac_sched_pkg::CTRL_ENABLE_BIT];
    assign output_drive = control[dac_sched_pkg::CTRL_ENABLE_BIT];

    ////////////////////////////////////////////////////////////////////
    // checks

    chk_write_loads_code: assert property (
        @(posedge pclk) disable iff (!presetn)
        (high_write && mode == dac_sched_pkg::MODE_ON_WRITE)
        |=> ##1 ((code == $past(word)) && update_pulse))
        else $error("high-byte write did not load the latch");

    chk_timer_mode_holds: assert property (
        @(posedge pclk) disable iff (!presetn)
        (mode != dac_sched_pkg::MODE_ON_WRITE && !load)
        |=> $stable(code))
        else $error("latch changed without its timer overflow");

    chk_timer3_loads: assert property (
        @(posedge pclk) disable iff (!presetn)
        (timer3_ovf && mode == dac_sched_pkg::MODE_TIMER3)
        |=> code == $past(word))
        else $error("timer 3 overflow did not load the latch");

    chk_one_load_each: assert property (
        @(posedge pclk) disable iff (!presetn)
        update_pulse |-> $past(load))
        else $error("latch update without an event");

endmodule : dac_channel

`default_nettype wire

// ===== design/dual_dac_update_scheduler.sv
/*
 * Top of the dual converter update scheduler: APB register file with
 * data and control bytes for two channels, and two channel instances.
 * Assumes an APB master, timer overflows as one-cycle pulses in the
 * pclk domain, and an analog stage that reads code and enable levels.
 */
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none

module dual_dac_update_scheduler (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer overflow pulses
    input wire logic timer2_ovf,
    input wire logic timer3_ovf,
    input wire logic timer4_ovf,
    // channel a converter side
    output logic [11:0] dac_a_code,
    output logic dac_a_power_on,
    output logic dac_a_output_en,
    // channel b converter side
    output logic [11:0] dac_b_code,
    output logic dac_b_power_on,
    output logic dac_b_output_en
);

    logic wr_en;
    logic rd_en;
    logic lane0;
    logic [7:0] dac_data_high_reg;
    logic [7:0] dac_data_low_reg;
    logic [7:0] dac_control_reg;
    logic [7:0] dac_b_data_high_reg;
    logic [7:0] dac_b_data_low_reg;
    logic [7:0] dac_b_control_reg;
    logic [31:0] prdata_reg;
    logic [31:0] rd_next;
    logic mapped;
    logic a_upd;
    logic b_upd;
    logic [1:0] upd_seen_reg;

    // zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign lane0 = pstrb[0];

    // address decode, also used for the error answer
    always_comb begin
        case (paddr)
            dac_sched_pkg::ADDR_DATA_HIGH,
            dac_sched_pkg::ADDR_DATA_LOW,
            dac_sched_pkg::ADDR_CONTROL,
            dac_sched_pkg::ADDR_B_DATA_HIGH,
            dac_sched_pkg::ADDR_B_DATA_LOW,
            dac_sched_pkg::ADDR_B_CONTROL,
            dac_sched_pkg::ADDR_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !mapped;

    ////////////////////////////////////////////////////////////////////
    // channel a registers

    // data bytes are held; only the channel decides when they count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_data_high_reg <= dac_sched_pkg::DATA_RESET;
            dac_data_low_reg <= dac_sched_pkg::DATA_RESET;
        end else if (wr_en && lane0) begin
            if (paddr == dac_sched_pkg::ADDR_DATA_HIGH) begin
                dac_data_high_reg <= pwdata[7:0];
            end
            if (paddr == dac_sched_pkg::ADDR_DATA_LOW) begin
                dac_data_low_reg <= pwdata[7:0];
            end
        end
    end

    // control: unused bits 6:5 never store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_control_reg <= dac_sched_pkg::CTRL_RESET;
        end else if (wr_en && lane0
                     && paddr == dac_sched_pkg::ADDR_CONTROL) begin
            dac_control_reg <= pwdata[7:0]
                               & dac_sched_pkg::CTRL_WRITE_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // channel b registers, independent of channel a

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_b_data_high_reg <= dac_sched_pkg::DATA_RESET;
            dac_b_data_low_reg <= dac_sched_pkg::DATA_RESET;
        end else if (wr_en && lane0) begin
            if (paddr == dac_sched_pkg::ADDR_B_DATA_HIGH) begin
                dac_b_data_high_reg <= pwdata[7:0];
            end
            if (paddr == dac_sched_pkg::ADDR_B_DATA_LOW) begin
                dac_b_data_low_reg <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_b_control_reg <= dac_sched_pkg::CTRL_RESET;
        end else if (wr_en && lane0
                     && paddr == dac_sched_pkg::ADDR_B_CONTROL) begin
            dac_b_control_reg <= pwdata[7:0]
                                 & dac_sched_pkg::CTRL_WRITE_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status: sticky per-channel update seen, cleared by writing ones;
    // a new update in the clearing cycle wins so none is lost

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upd_seen_reg <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == 0) ? a_upd : b_upd) begin
                    upd_seen_reg[i] <= 1'b1;
                end else if (wr_en && lane0 && pwdata[i]
                             && paddr == dac_sched_pkg::ADDR_STATUS) begin
                    upd_seen_reg[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path, registered so data comes from flip-flops

    always_comb begin
        rd_next = 32'h0000_0000;
        case (paddr)
            dac_sched_pkg::ADDR_DATA_HIGH: rd_next[7:0] = dac_data_high_reg;
            dac_sched_pkg::ADDR_DATA_LOW: rd_next[7:0] = dac_data_low_reg;
            dac_sched_pkg::ADDR_CONTROL: rd_next[7:0] = dac_control_reg;
            dac_sched_pkg::ADDR_B_DATA_HIGH:
                rd_next[7:0] = dac_b_data_high_reg;
            dac_sched_pkg::ADDR_B_DATA_LOW: rd_next[7:0] = dac_b_data_low_reg;
            dac_sched_pkg::ADDR_B_CONTROL: rd_next[7:0] = dac_b_control_reg;
            dac_sched_pkg::ADDR_STATUS: rd_next[1:0] = upd_seen_reg;
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // capture in the setup cycle so data is ready in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= rd_next;
        end
    end
    assign prdata = rd_en ? prdata_reg : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////
    // the two channels

    dac_channel u_chan_a (
        .pclk(pclk),
        .presetn(presetn),
        .data_high(dac_data_high_reg),
        .data_low(dac_data_low_reg),
        .control(dac_control_reg),
        .high_write(wr_en && lane0
                    && paddr == dac_sched_pkg::ADDR_DATA_HIGH),
        .timer2_ovf(timer2_ovf),
        .timer3_ovf(timer3_ovf),
        .timer4_ovf(timer4_ovf),
        .code(dac_a_code),
        .converter_on(dac_a_power_on),
        .output_drive(dac_a_output_en),
        .update_pulse(a_upd)
    );

    // high-byte write reaches the channel in the same edge as the data,
    // so the latch sees the byte one cycle later from the register
    dac_channel u_chan_b (
        .pclk(pclk),
        .presetn(presetn),
        .data_high(dac_b_data_high_reg),
        .data_low(dac_b_data_low_reg),
        .control(dac_b_control_reg),
        .high_write(wr_en && lane0
                    && paddr == dac_sched_pkg::ADDR_B_DATA_HIGH),
        .timer2_ovf(timer2_ovf),
        .timer3_ovf(timer3_ovf),
        .timer4_ovf(timer4_ovf),
        .code(dac_b_code),
        .converter_on(dac_b_power_on),
        .output_drive(dac_b_output_en),
        .update_pulse(b_upd)
    );

    ////////////////////////////////////////////////////////////////////
    // checks

    chk_ctrl_unused_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        dac_control_reg[6:5] == 2'h0 && dac_b_control_reg[6:5] == 2'h0)
        else $error("unused control bits stored a value");

    chk_low_write_holds: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == dac_sched_pkg::ADDR_DATA_LOW
         && dac_control_reg[4:3] == 2'h0)
        |=> $stable(dac_a_code))
        else $error("low-byte write changed the output");

    chk_disable_floats: assert property (
        @(posedge pclk) disable iff (!presetn)
        !dac_control_reg[7] |-> !dac_a_output_en && !dac_a_power_on)
        else $error("disabled channel still driving");

    chk_b_independent: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == dac_sched_pkg::ADDR_DATA_HIGH)
        |=> $stable(dac_b_code))
        else $error("channel a write disturbed channel b");

endmodule : dual_dac_update_scheduler

`default_nettype wire

// ===== sim/test_dual_dac_update_scheduler.sv
/*
 * Self-checking bench for the dual converter update scheduler.
 * Assumes dac_sched_pkg and the top module are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
$display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module test_dual_dac_update_scheduler;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic timer2_ovf, timer3_ovf, timer4_ovf;
    logic [11:0] dac_a_code, dac_b_code;
    logic dac_a_power_on, dac_a_output_en, dac_b_power_on, dac_b_output_en;
    int num_errors;
    int n_checks;

    dual_dac_update_scheduler DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer2_ovf(timer2_ovf),
        .timer3_ovf(timer3_ovf), .timer4_ovf(timer4_ovf),
        .dac_a_code(dac_a_code), .dac_a_power_on(dac_a_power_on),
        .dac_a_output_en(dac_a_output_en), .dac_b_code(dac_b_code),
        .dac_b_power_on(dac_b_power_on), .dac_b_output_en(dac_b_output_en));

    ////////////////////////////////////////////////////////////////////////
    // clock, 4 ns period
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // cuts a hang short; the full run needs about 700 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    // one apb transfer; the answer is taken at the rising edge at which
    // pready is sampled high, and only then is the request released
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, 4'hf, rd, er);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 8'h00, 4'hf, rd, er);
        `CHK(rd, {24'h000000, e})
    endtask : rd_chk

    // channel b sits 0x0c above channel a
    function automatic logic [7:0] ad(input int ch, input logic [7:0] b);
        return b + ((ch != 0) ? 8'h0c : 8'h00);
    endfunction : ad

    function automatic logic [11:0] cd(input int ch);
        return (ch != 0) ? dac_b_code : dac_a_code;
    endfunction : cd

    function automatic logic [1:0] en(input int ch);
        return (ch != 0) ? {dac_b_power_on, dac_b_output_en}
                         : {dac_a_power_on, dac_a_output_en};
    endfunction : en

    // expected word for each justification
    function automatic logic [11:0] just(input logic [2:0] f,
                                         input logic [7:0] h,
                                         input logic [7:0] l);
        case (f)
            3'h0: return {h[3:0], l};
            3'h1: return {h[4:0], l[7:1]};
            3'h2: return {h[5:0], l[7:2]};
            3'h3: return {h[6:0], l[7:3]};
            default: return {h, l[7:4]};
        endcase
    endfunction : just

    task automatic settle();
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask : settle

    // one-cycle overflow pulse of timer t (2, 3 or 4)
    task automatic pulse(input int t);
        @(posedge pclk);
        {timer4_ovf, timer3_ovf, timer2_ovf} <= 3'h1 << (t - 2);
        @(posedge pclk);
        {timer4_ovf, timer3_ovf, timer2_ovf} <= 3'h0;
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_vals();
        for (int ch = 0; ch < 2; ch++) begin
            rd_chk(ad(ch, dac_sched_pkg::ADDR_CONTROL), 8'h00);
            rd_chk(ad(ch, dac_sched_pkg::ADDR_DATA_HIGH), 8'h00);
            rd_chk(ad(ch, dac_sched_pkg::ADDR_DATA_LOW), 8'h00);
            `CHK(cd(ch), 12'h000)
            `CHK(en(ch), 2'b00)
        end
    endtask : t_reset_vals

    // unused bits read zero; enable drives power and output together
    task automatic t_ctrl_mask(input int ch);
        wr(ad(ch, dac_sched_pkg::ADDR_CONTROL), 8'hff);
        rd_chk(ad(ch, dac_sched_pkg::ADDR_CONTROL), 8'h9f);
        settle();
        `CHK(en(ch), 2'b11)
        wr(ad(ch, dac_sched_pkg::ADDR_CONTROL), 8'h60);
        rd_chk(ad(ch, dac_sched_pkg::ADDR_CONTROL), 8'h00);
        settle();
        `CHK(en(ch), 2'b00)
    endtask : t_ctrl_mask

    // write-triggered mode through every format, then both range ends
    task automatic t_on_write(input int ch);
        logic [2:0] f;
        logic [7:0] h;
        logic [11:0] old;
        for (int i = 0; i < 8; i++) begin
            f = 3'(i);
            h = 8'h96 + 8'(i);
            wr(ad(ch, dac_sched_pkg::ADDR_CONTROL), {5'h10, f});
            old = cd(ch);
            wr(ad(ch, dac_sched_pkg::ADDR_DATA_LOW), 8'he7);
            settle();
            `CHK(cd(ch), old)
            wr(ad(ch, dac_sched_pkg::ADDR_DATA_HIGH), h);
            settle();
            `CHK(cd(ch), just(f, h, 8'he7))
            wr(ad(ch, dac_sched_pkg::ADDR_DATA_HIGH), ~h);
            settle();
            `CHK(cd(ch), just(f, ~h, 8'he7))
        end
        wr(ad(ch, dac_sched_pkg::ADDR_CONTROL), 8'h80);
        wr(ad(ch, dac_sched_pkg::ADDR_DATA_LOW), 8'hff);
        wr(ad(ch, dac_sched_pkg::ADDR_DATA_HIGH), 8'h0f);
        settle();
        `CHK(cd(ch), 12'hfff)
        wr(ad(ch, dac_sched_pkg::ADDR_DATA_LOW), 8'h00);
        wr(ad(ch, dac_sched_pkg::ADDR_DATA_HIGH), 8'h00);
        settle();
        `CHK(cd(ch), 12'h000)
    endtask : t_on_write

    // timer modes: other timers ignored, one load per selected pulse
    task automatic t_timer(input int ch);
        logic [11:0] other, old;
        logic [7:0] h;
        int tm;
        other = cd(1 - ch);
        for (int m = 1; m < 4; m++) begin
            tm = (m == 1) ? 3 : ((m == 2) ? 4 : 2);
            h = 8'h40 + 8'(m);
            wr(ad(ch, dac_sched_pkg::ADDR_CONTROL), {3'h4, 2'(m), 3'h2});
            old = cd(ch);
            wr(ad(ch, dac_sched_pkg::ADDR_DATA_LOW), 8'hb4);
            wr(ad(ch, dac_sched_pkg::ADDR_DATA_HIGH), h);
            settle();
            `CHK(cd(ch), old)
            for (int t = 2; t < 5; t++) begin
                if (t != tm) begin
                    pulse(t);
                end
            end
            settle();
            `CHK(cd(ch), old)
            pulse(tm);
            settle();
            `CHK(cd(ch), just(3'h2, h, 8'hb4))
            wr(ad(ch, dac_sched_pkg::ADDR_DATA_HIGH), ~h);
            settle();
            `CHK(cd(ch), just(3'h2, h, 8'hb4))
        end
        wr(ad(ch, dac_sched_pkg::ADDR_CONTROL), 8'h00);
        `CHK(cd(1 - ch), other)
    endtask : t_timer

    // unmapped places answer with an error; unstrobed writes are dropped
    task automatic t_refused();
        logic [31:0] rd;
        logic er;
        apb(1'b0, 8'h1c, 8'h00, 4'hf, rd, er);
        `CHK(er, 1'b1)
        `CHK(rd, 32'h00000000)
        apb(1'b1, 8'h40, 8'hff, 4'hf, rd, er);
        `CHK(er, 1'b1)
        apb(1'b1, dac_sched_pkg::ADDR_CONTROL, 8'h9f, 4'he, rd, er);
        rd_chk(dac_sched_pkg::ADDR_CONTROL, 8'h00);
    endtask : t_refused

    // status flags: set by each latch load, cleared by writing ones
    task automatic t_status();
        wr(dac_sched_pkg::ADDR_STATUS, 8'h03);
        rd_chk(dac_sched_pkg::ADDR_STATUS, 8'h00);
        wr(dac_sched_pkg::ADDR_CONTROL, 8'h80);
        wr(dac_sched_pkg::ADDR_DATA_HIGH, 8'h12);
        settle();
        rd_chk(dac_sched_pkg::ADDR_STATUS, 8'h01);
        wr(ad(1, dac_sched_pkg::ADDR_CONTROL), 8'h88);
        pulse(3);
        settle();
        rd_chk(dac_sched_pkg::ADDR_STATUS, 8'h03);
        wr(dac_sched_pkg::ADDR_STATUS, 8'h01);
        rd_chk(dac_sched_pkg::ADDR_STATUS, 8'h02);
    endtask : t_status

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        num_errors = 0;
        n_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        pstrb = 4'hf;
        {timer4_ovf, timer3_ovf, timer2_ovf} = 3'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_vals();
        for (int ch = 0; ch < 2; ch++) begin
            t_ctrl_mask(ch);
            t_on_write(ch);
            t_timer(ch);
        end
        t_refused();
        t_status();
        wrap_up();
    end
endmodule : test_dual_dac_update_scheduler
`default_nettype wire
